/* File: verilog/fber_pkg.sv */
// Purpose: shared constants for the flash erase/row-program sequencer and its core-side controller
// Assumes: 20 MHz system clock, synchronous active-low reset
// Notes: cycle counts derive from the time constants below
`default_nettype none
package fber_pkg;
    // =========================================================
    // timing
    localparam int unsigned CLK_NS = 50;
    localparam int unsigned ERASE_TIME_NS = 2000;
    localparam int unsigned PROG_TIME_NS = 1500;
    localparam int unsigned ERASE_CYC = (ERASE_TIME_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned PROG_CYC = (PROG_TIME_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W = 12;
    // =========================================================
    // geometry
    localparam int ROW_WORDS = 64;
    localparam int BLOCK_ROWS = 8;
    localparam int BLOCK_WORDS = ROW_WORDS * BLOCK_ROWS;
    localparam int ROW_ALIGN_BITS = 7;
    localparam int BLOCK_ALIGN_BITS = 10;
    localparam int IDX_W = 6;
    localparam int WORD_W = 24;
    // =========================================================
    // memory_op_control fields
    localparam int CTL_OP_LSB = 0;
    localparam int CTL_OP_W = 4;
    localparam int CTL_ERASE_BIT = 6;
    localparam int CTL_WRITE_ENABLE_BIT_BIT = 14;
    localparam int CTL_START_BIT = 15;
    localparam logic [15:0] CTL_RESET = 16'h0000;
    localparam logic [3:0] OP_ERASE_BLOCK = 4'h2;
    localparam logic [3:0] OP_PROG_ROW = 4'h1;
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'haa;
    localparam logic [7:0] PAGE_RESET = 8'h00;
    // =========================================================
    // core-side register selects
    localparam logic [1:0] SEL_CTL = 2'h0;
    localparam logic [1:0] SEL_KEY = 2'h1;
    localparam logic [1:0] SEL_PAGE = 2'h2;
    // =========================================================
    // controller wishbone map and pacing
    localparam logic [7:0] ADR_TARGET = 8'h00;
    localparam logic [7:0] ADR_DATA = 8'h04;
    localparam logic [7:0] ADR_TBL = 8'h08;
    localparam logic [7:0] ADR_STAT = 8'h0c;
    localparam int STAT_STALL_BIT = 16;
    localparam int STAT_HOLD_BIT = 17;
    localparam logic [1:0] NOP_SLOTS = 2'h2;
    localparam logic [2:0] IRQ_HOLD_SLOTS = 3'h5;
endpackage
`default_nettype wire

/* File: verilog/fber_bus_if.sv */
// Purpose: core-to-sequencer link: register writes, table writes, stall
// Assumes: all signals on the one system clock
// Notes: write strobes are one-cycle pulses
`timescale 1ns/100ps
`default_nettype none
interface fber_bus_if;
    logic reg_wr;
    logic [1:0] reg_sel;
    logic [15:0] reg_wdata;
    logic tbl_wr;
    logic [15:0] tbl_off;
    logic [23:0] tbl_data;
    logic [15:0] ctl_rdata;
    logic stall;
    modport dev (
        input reg_wr, reg_sel, reg_wdata, tbl_wr, tbl_off, tbl_data,
        output ctl_rdata, stall
    );
    modport core (
        output reg_wr, reg_sel, reg_wdata, tbl_wr, tbl_off, tbl_data,
        input ctl_rdata, stall
    );
endinterface
`default_nettype wire

/* File: verilog/fber_key_unlock.sv */
// Purpose: two-write unlock key detector
// Assumes: strobes are one-cycle pulses on the system clock
// Notes: armed stays until any other write or the next key write
`timescale 1ns/100ps
`default_nettype none
module fber_key_unlock (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // writes
    input wire logic key_wr_i,
    input wire logic [7:0] key_data_i,
    input wire logic other_wr_i,
    // status
    output logic armed_o
);
    typedef struct packed {
        logic half;
        logic armed;
    } fber_key_st_t;
    fber_key_st_t st_reg, st_next;

    always_comb begin
        st_next = st_reg;
        if (other_wr_i) begin
            st_next.half = 1'b0;
            st_next.armed = 1'b0;
        end else if (key_wr_i) begin
            st_next.armed = st_reg.half && (key_data_i == fber_pkg::KEY_SECOND);
            st_next.half = (key_data_i == fber_pkg::KEY_FIRST);
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign armed_o = st_reg.armed;
endmodule // fber_key_unlock
`default_nettype wire

/* File: verilog/fber_dev.sv */
// Purpose: flash block erase / row program sequencer
// Assumes: core does not write while stall is high
// Notes: flash array is driven by one-cycle erase and word-write strobes
//
// Local design decisions: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module fber_dev #(
    parameter int ROW_WORDS = fber_pkg::ROW_WORDS
) (
    // clock and reset
    input wire logic SYS_CLK_I,
    input wire logic NRST_I,
    // core link
    fber_bus_if.dev BUS,
    // flash array
    output logic FLASH_ERASE_O,
    output logic FLASH_WE_O,
    output logic [23:0] FLASH_ADDR_O,
    output logic [23:0] FLASH_DATA_O
);
    // =========================================================
    // elaboration checks
    // latch index and row field are sized by the package
    if (ROW_WORDS != (1 << fber_pkg::IDX_W)) begin : g_chk_row_words
        $error("ROW_WORDS must match the latch index width");
    end
    // two address units per instruction word
    if ((2 * ROW_WORDS) != (1 << fber_pkg::ROW_ALIGN_BITS)) begin : g_chk_row_align
        $error("row alignment does not match ROW_WORDS");
    end
    if ((ROW_WORDS * fber_pkg::BLOCK_ROWS) != fber_pkg::BLOCK_WORDS) begin : g_chk_block_words
        $error("block size is not eight rows");
    end
    if ((2 * fber_pkg::BLOCK_WORDS) != (1 << fber_pkg::BLOCK_ALIGN_BITS)) begin : g_chk_block_align
        $error("block alignment does not match the block size");
    end
    // counts are loaded minus one: zero would wrap the counter
    if ((fber_pkg::ERASE_CYC == 0) || (fber_pkg::PROG_CYC == 0)) begin : g_chk_zero_cnt
        $error("erase and program times must be nonzero");
    end
    if (fber_pkg::ERASE_CYC > (1 << fber_pkg::CNT_W)) begin : g_chk_erase_cnt
        $error("wait counter too narrow for the erase time");
    end
    if (fber_pkg::PROG_CYC > (1 << fber_pkg::CNT_W)) begin : g_chk_prog_cnt
        $error("wait counter too narrow for the program time");
    end

    typedef enum logic [1:0] {ST_IDLE, ST_ERASE, ST_PROG, ST_WAIT} fber_state_t;
    typedef struct packed {
        fber_state_t state;
        logic [15:0] ctl;
        logic [7:0] page;
        logic [15:0] off;
        logic [fber_pkg::CNT_W-1:0] cnt;
        logic [fber_pkg::IDX_W-1:0] idx;
        logic erase;
        logic we;
        logic [23:0] faddr;
        logic [23:0] fdata;
    } fber_dev_st_t;
    fber_dev_st_t st_reg, st_next;

    logic [fber_pkg::WORD_W-1:0] latch_mem [ROW_WORDS];
    logic armed;
    logic idle;
    logic key_wr;
    logic other_wr;
    logic ctl_wr;
    logic [3:0] wop;
    logic werase;
    logic wwren;
    logic go_erase;
    logic go_prog;
    logic [23:0] full_addr;

    // =========================================================
    // unlock
    // writes seen while busy neither arm nor disarm the key
    assign idle = (st_reg.state == ST_IDLE);
    assign key_wr = BUS.reg_wr && (BUS.reg_sel == fber_pkg::SEL_KEY) && idle;
    assign other_wr = idle && (BUS.tbl_wr || (BUS.reg_wr && (BUS.reg_sel != fber_pkg::SEL_KEY)));

    fber_key_unlock u_key (
        .clk_i(SYS_CLK_I),
        .rst_n_i(NRST_I),
        .key_wr_i(key_wr),
        .key_data_i(BUS.reg_wdata[7:0]),
        .other_wr_i(other_wr),
        .armed_o(armed)
    );

    // =========================================================
    // write latches
    // latches are not cleared after a row is programmed
    // latch table writes
    always_ff @(posedge SYS_CLK_I) begin
        if (BUS.tbl_wr && (st_reg.state == ST_IDLE)) begin
            latch_mem[BUS.tbl_off[fber_pkg::IDX_W:1]] <= BUS.tbl_data;
        end
    end

    // =========================================================
    // start decode
    // control writes while busy are dropped, not queued
    assign ctl_wr = BUS.reg_wr && (BUS.reg_sel == fber_pkg::SEL_CTL) && (st_reg.state == ST_IDLE);
    assign wop = BUS.reg_wdata[fber_pkg::CTL_OP_LSB +: fber_pkg::CTL_OP_W];
    assign werase = BUS.reg_wdata[fber_pkg::CTL_ERASE_BIT];
    assign wwren = BUS.reg_wdata[fber_pkg::CTL_WRITE_ENABLE_BIT_BIT];
    assign full_addr = {st_reg.page, st_reg.off};

    always_comb begin
        go_erase = 1'b0;
        go_prog = 1'b0;
        if (ctl_wr && BUS.reg_wdata[fber_pkg::CTL_START_BIT] && armed && wwren) begin
            go_erase = (wop == fber_pkg::OP_ERASE_BLOCK) && werase;
            go_prog = (wop == fber_pkg::OP_PROG_ROW) && !werase;
        end
    end

    // =========================================================
    // sequencer
    always_comb begin
        st_next = st_reg;
        st_next.erase = 1'b0;
        st_next.we = 1'b0;
        if (BUS.tbl_wr && (st_reg.state == ST_IDLE)) begin
            st_next.off = BUS.tbl_off;
        end
        case (st_reg.state)
            ST_IDLE: begin
                if (BUS.reg_wr && (BUS.reg_sel == fber_pkg::SEL_PAGE)) begin
                    st_next.page = BUS.reg_wdata[7:0];
                end
                if (ctl_wr) begin
                    st_next.ctl = BUS.reg_wdata;
                    st_next.ctl[fber_pkg::CTL_START_BIT] = go_erase || go_prog;
                end
                if (go_erase) begin
                    st_next.state = ST_ERASE;
                end else if (go_prog) begin
                    st_next.state = ST_PROG;
                    st_next.idx = '0;
                end
            end
            ST_ERASE: begin
                st_next.erase = 1'b1;
                st_next.faddr = {full_addr[23:fber_pkg::BLOCK_ALIGN_BITS],
                                 {fber_pkg::BLOCK_ALIGN_BITS{1'b0}}};
                st_next.cnt = fber_pkg::CNT_W'(fber_pkg::ERASE_CYC - 1);
                st_next.state = ST_WAIT;
            end
            ST_PROG: begin
                // one word per cycle
                // latches are steady: table writes wait while busy
                st_next.we = 1'b1;
                st_next.faddr = {full_addr[23:fber_pkg::ROW_ALIGN_BITS], st_reg.idx, 1'b0};
                st_next.fdata = latch_mem[st_reg.idx];
                st_next.idx = st_reg.idx + 1'b1;
                if (st_reg.idx == fber_pkg::IDX_W'(ROW_WORDS - 1)) begin
                    st_next.cnt = fber_pkg::CNT_W'(fber_pkg::PROG_CYC - 1);
                    st_next.state = ST_WAIT;
                end
            end
            ST_WAIT: begin
                st_next.cnt = st_reg.cnt - 1'b1;
                if (st_reg.cnt == '0) begin
                    st_next.ctl[fber_pkg::CTL_START_BIT] = 1'b0;
                    st_next.state = ST_IDLE;
                end
            end
            default: begin
                st_next.state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (!NRST_I) begin
            st_reg <= '0;
            st_reg.state <= ST_IDLE;
            st_reg.ctl <= fber_pkg::CTL_RESET;
            st_reg.page <= fber_pkg::PAGE_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // =========================================================
    // outputs
    // straight from the state so the next core access is held at once
    // core stalled while busy
    assign BUS.stall = (st_reg.state != ST_IDLE);
    assign BUS.ctl_rdata = st_reg.ctl;
    assign FLASH_ERASE_O = st_reg.erase;
    assign FLASH_WE_O = st_reg.we;
    assign FLASH_ADDR_O = st_reg.faddr;
    assign FLASH_DATA_O = st_reg.fdata;
endmodule // fber_dev
`default_nettype wire

/* File: verilog/fber_host.sv */
// Purpose: core-side controller: wishbone orders become link writes
// Assumes: software issues the unlock and start sequence itself
// Notes: ack of data and table writes is held back while the sequencer stalls the core
`timescale 1ns/100ps
`default_nettype none
module fber_host (
    // clock and reset
    input wire logic SYS_CLK_I,
    input wire logic NRST_I,
    // wishbone slave
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [31:0] WB_DAT_I,
    input wire logic [3:0] WB_SEL_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    // interrupt hold toward the interrupt controller
    output logic IRQ_HOLD_O,
    // sequencer link
    fber_bus_if.core BUS
);
    typedef struct packed {
        logic [31:0] target;
        logic ack;
        logic [31:0] dat;
        logic [1:0] gap;
        logic [2:0] hold;
        logic reg_wr;
        logic [15:0] wdata;
        logic tbl_wr;
        logic [23:0] tdata;
    } fber_host_st_t;
    fber_host_st_t st_reg, st_next;

    logic req;
    logic can_issue;
    logic [1:0] tsel;

    assign req = WB_CYC_I && WB_STB_I && !st_reg.ack;
    assign tsel = st_reg.target[1:0];
    assign can_issue = !BUS.stall && (st_reg.gap == '0);

    always_comb begin
        st_next = st_reg;
        st_next.ack = 1'b0;
        st_next.reg_wr = 1'b0;
        st_next.tbl_wr = 1'b0;
        if (st_reg.gap != '0 && !BUS.stall) begin
            st_next.gap = st_reg.gap - 1'b1;
        end
        if (req && WB_WE_I) begin
            case (WB_ADR_I)
                fber_pkg::ADR_TARGET: begin
                    for (int b = 0; b < 4; b++) begin
                        if (WB_SEL_I[b]) begin
                            st_next.target[8*b +: 8] = WB_DAT_I[8*b +: 8];
                        end
                    end
                    st_next.ack = 1'b1;
                end
                fber_pkg::ADR_DATA: begin
                    if (can_issue) begin
                        st_next.reg_wr = 1'b1;
                        st_next.wdata = WB_DAT_I[15:0];
                        st_next.ack = 1'b1;
                        if (st_reg.hold != '0) begin
                            st_next.hold = st_reg.hold - 1'b1;
                        end
                        if (tsel == fber_pkg::SEL_KEY && WB_DAT_I[7:0] == fber_pkg::KEY_FIRST) begin
                            st_next.hold = fber_pkg::IRQ_HOLD_SLOTS;
                        end
                        if (tsel == fber_pkg::SEL_CTL && WB_DAT_I[fber_pkg::CTL_START_BIT]) begin
                            st_next.gap = fber_pkg::NOP_SLOTS;
                        end
                    end
                end
                fber_pkg::ADR_TBL: begin
                    if (can_issue) begin
                        st_next.tbl_wr = 1'b1;
                        st_next.tdata = WB_DAT_I[23:0];
                        st_next.ack = 1'b1;
                        if (st_reg.hold != '0) begin
                            st_next.hold = st_reg.hold - 1'b1;
                        end
                    end
                end
                default: begin
                    st_next.ack = 1'b1;
                end
            endcase
        end else if (req) begin
            st_next.ack = 1'b1;
            case (WB_ADR_I)
                fber_pkg::ADR_TARGET: st_next.dat = st_reg.target;
                fber_pkg::ADR_STAT: begin
                    st_next.dat = {16'h0000, BUS.ctl_rdata};
                    st_next.dat[fber_pkg::STAT_STALL_BIT] = BUS.stall;
                    st_next.dat[fber_pkg::STAT_HOLD_BIT] = (st_reg.hold != '0);
                end
                default: st_next.dat = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (!NRST_I) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign WB_ACK_O = st_reg.ack;
    assign WB_DAT_O = st_reg.dat;
    assign IRQ_HOLD_O = (st_reg.hold != '0);
    assign BUS.reg_wr = st_reg.reg_wr;
    assign BUS.reg_sel = tsel;
    assign BUS.reg_wdata = st_reg.wdata;
    assign BUS.tbl_wr = st_reg.tbl_wr;
    assign BUS.tbl_off = st_reg.target[31:16];
    assign BUS.tbl_data = st_reg.tdata;
endmodule // fber_host
`default_nettype wire

/* File: bench/fber_properties.sv */
// Purpose: link and flash-side properties of the sequencer pair
// Assumes: one clock, synchronous active-low reset
// Notes: key tracking mirrors the unlock order on the link
`timescale 1ns/100ps
`default_nettype none
module fber_properties (
    // clock and reset
    input wire logic SYS_CLK_I,
    input wire logic NRST_I,
    // link
    input wire logic reg_wr,
    input wire logic [1:0] reg_sel,
    input wire logic [15:0] reg_wdata,
    input wire logic tbl_wr,
    input wire logic [15:0] ctl_rdata,
    input wire logic stall,
    // flash array
    input wire logic FLASH_ERASE_O,
    input wire logic FLASH_WE_O,
    input wire logic [23:0] FLASH_ADDR_O
);
    default clocking cb @(posedge SYS_CLK_I);
    endclocking
    default disable iff (!NRST_I);
    // ==========
    // helper state
    typedef struct packed {logic half; logic armed; logic [6:0] run;} fber_chk_t;
    fber_chk_t st_reg, st_next;
    logic key_wr;
    assign key_wr = reg_wr && reg_sel == fber_pkg::SEL_KEY;
    always_comb begin
        st_next = st_reg;
        // writes during stall are dropped, so they must not touch the key
        if ((reg_wr || tbl_wr) && !stall) begin
            st_next.half = key_wr && reg_wdata[7:0] == fber_pkg::KEY_FIRST;
            st_next.armed = key_wr && st_reg.half && reg_wdata[7:0] == fber_pkg::KEY_SECOND;
        end
        st_next.run = FLASH_WE_O ? st_reg.run + 7'h01 : 7'h00;
    end
    always_ff @(posedge SYS_CLK_I) begin
        if (!NRST_I) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
    // ==========
    // properties
    AST_START_SHOWN: assert property (stall |-> ctl_rdata[15])
        else $error("start bit low while stalled");
    AST_STALL_CAUSE: assert property ($rose(stall) |-> $past(reg_wr && reg_sel == fber_pkg::SEL_CTL && reg_wdata[15]))
        else $error("stall without a start write");
    AST_WRITE_ENABLE_BIT_NEEDED: assert property ($rose(stall) |-> $past(reg_wdata[14]))
        else $error("cycle started with write enable clear");
    AST_KEY_NEEDED: assert property ($rose(stall) |-> $past(st_reg.armed))
        else $error("cycle started without unlock");
    AST_SELF_CLEAR: assert property ($fell(stall) |-> !ctl_rdata[15])
        else $error("start bit not cleared at cycle end");
    AST_ERASE_NEXT: assert property ($rose(stall) && $past(reg_wdata[3:0]) == fber_pkg::OP_ERASE_BLOCK |=> FLASH_ERASE_O)
        else $error("erase pulse missing");
    AST_ERASE_MODE: assert property (FLASH_ERASE_O |-> ctl_rdata[3:0] == fber_pkg::OP_ERASE_BLOCK && ctl_rdata[6])
        else $error("erase under wrong mode");
    AST_ERASE_ALIGN: assert property (FLASH_ERASE_O |-> FLASH_ADDR_O[9:0] == 10'h000)
        else $error("erase address not block aligned");
    AST_FLASH_GATED: assert property (FLASH_ERASE_O || FLASH_WE_O |-> stall)
        else $error("flash strobe outside a cycle");
    AST_ROW_LEN: assert property ($fell(FLASH_WE_O) |-> st_reg.run == 7'h40)
        else $error("row burst not 64 words");
    AST_ROW_STEP: assert property (FLASH_WE_O && $past(FLASH_WE_O) |-> FLASH_ADDR_O == $past(FLASH_ADDR_O) + 24'h000002)
        else $error("row address step wrong");
    AST_PROG_MODE: assert property (FLASH_WE_O |-> ctl_rdata[3:0] == fber_pkg::OP_PROG_ROW && !ctl_rdata[6])
        else $error("word write under wrong mode");
    AST_QUIET_LINK: assert property (stall |-> !reg_wr && !tbl_wr)
        else $error("link write while stalled");
endmodule // fber_properties
`default_nettype wire

/* File: bench/fber_tb.sv */
// Purpose: self-checking bench for controller and sequencer
// Assumes: 20 MHz clock, wishbone classic master
// Notes: flash strobes are sampled by a monitor
`timescale 1ns/100ps
`default_nettype none
module fber_tb;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [3:0] sel = 4'h0;
    logic [31:0] rdat, st;
    logic ack, irq_hold, f_erase, f_we;
    logic [23:0] f_addr, f_data, erase_addr;
    logic [23:0] row_base = 24'h0;
    int failures = 0, total_checks = 0, cycles = 0;
    int erase_cnt = 0, we_cnt = 0, stall_cyc = 0;
    fber_bus_if bus();
    fber_host u_fber_host (.SYS_CLK_I(sys_clk), .NRST_I(nrst), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_DAT_I(wdat), .WB_SEL_I(sel), .WB_DAT_O(rdat),
        .WB_ACK_O(ack), .IRQ_HOLD_O(irq_hold), .BUS(bus));
    fber_dev u_fber_dev (.SYS_CLK_I(sys_clk), .NRST_I(nrst), .BUS(bus), .FLASH_ERASE_O(f_erase),
        .FLASH_WE_O(f_we), .FLASH_ADDR_O(f_addr), .FLASH_DATA_O(f_data));
    fber_properties u_fber_properties (.SYS_CLK_I(sys_clk), .NRST_I(nrst), .reg_wr(bus.reg_wr),
        .reg_sel(bus.reg_sel), .reg_wdata(bus.reg_wdata), .tbl_wr(bus.tbl_wr),
        .ctl_rdata(bus.ctl_rdata), .stall(bus.stall), .FLASH_ERASE_O(f_erase),
        .FLASH_WE_O(f_we), .FLASH_ADDR_O(f_addr));
    always #25 sys_clk = ~sys_clk;
    // ==========
    // checking
    task automatic summarize();
        if (failures == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask
    always @(posedge sys_clk) begin
        cycles++;
        if (nrst && bus.stall) stall_cyc++;
        if (nrst && f_erase) begin
            erase_cnt++;
            erase_addr = f_addr;
        end
        if (nrst && f_we) begin
            check("prog_addr", {8'h0, row_base + 24'(2 * we_cnt)}, {8'h0, f_addr});
            check("prog_data", {8'h0, 24'h5a0000 + 24'(we_cnt)}, {8'h0, f_data});
            we_cnt++;
        end
        if (cycles == 10000) begin
            failures++;
            summarize();
        end
    end
    // ==========
    // bus tasks
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        {cyc, stb, we} <= {2'b11, w};
        {adr, wdat, sel} <= {a, d, 4'hf};
        @(posedge sys_clk);
        while (ack !== 1'b1) @(posedge sys_clk);
        st = rdat;
        {cyc, stb, we} <= 3'b000;
        @(posedge sys_clk);
    endtask
    task automatic link(input logic [1:0] s, input logic [15:0] v);
        wb(1'b1, fber_pkg::ADR_TARGET, {30'h0, s});
        wb(1'b1, fber_pkg::ADR_DATA, {16'h0, v});
    endtask
    task automatic unlock();
        link(fber_pkg::SEL_KEY, {8'h0, fber_pkg::KEY_FIRST});
        link(fber_pkg::SEL_KEY, {8'h0, fber_pkg::KEY_SECOND});
    endtask
    // irq hold bit masked: its span counts data and table writes
    task automatic stat(input logic [31:0] exp, input string name);
        wb(1'b0, fber_pkg::ADR_STAT, 32'h0);
        check(name, exp, {15'h0, st[16:0]});
    endtask
    // ==========
    // scenarios
    task automatic t_refusals();
        stat(32'h0, "stat_after_reset");
        link(fber_pkg::SEL_CTL, 16'hc042);
        stat(32'h0000_4042, "ctl_no_key");
        link(fber_pkg::SEL_KEY, {8'h0, fber_pkg::KEY_FIRST});
        wb(1'b0, fber_pkg::ADR_STAT, 32'h0);
        check("irq_hold", 32'h1, {31'h0, st[17]});
        check("irq_hold_pin", 32'h1, {31'h0, irq_hold});
        link(fber_pkg::SEL_KEY, {8'h0, fber_pkg::KEY_SECOND});
        link(fber_pkg::SEL_CTL, 16'h8042);
        stat(32'h0000_0042, "ctl_no_write_enable_bit");
        link(fber_pkg::SEL_KEY, {8'h0, fber_pkg::KEY_FIRST});
        link(fber_pkg::SEL_PAGE, 16'h0012);
        link(fber_pkg::SEL_KEY, {8'h0, fber_pkg::KEY_SECOND});
        link(fber_pkg::SEL_CTL, 16'hc042);
        stat(32'h0000_4042, "ctl_split_key");
        check("erase_refused", 32'h0, erase_cnt);
    endtask
    task automatic t_erase();
        wb(1'b1, fber_pkg::ADR_TARGET, 32'h1234_0000);
        wb(1'b1, fber_pkg::ADR_TBL, 32'h0);
        unlock();
        stall_cyc = 0;
        link(fber_pkg::SEL_CTL, 16'hc042);
        stat(32'h0001_c042, "erase_running");
        do wb(1'b0, fber_pkg::ADR_STAT, 32'h0); while (st[16] !== 1'b0);
        stat(32'h0000_4042, "erase_done");
        check("erase_count", 32'h1, erase_cnt);
        check("erase_addr", 32'h0012_1000, {8'h0, erase_addr});
        // one erase-pulse cycle, then the full wait count
        check("erase_stall", 1 + fber_pkg::ERASE_CYC, stall_cyc);
    endtask
    task automatic t_program();
        row_base = 24'h121080;
        we_cnt = 0;
        for (int i = 0; i < fber_pkg::ROW_WORDS; i++) begin
            wb(1'b1, fber_pkg::ADR_TARGET, {16'h1080 + 16'(2 * i), 16'h0000});
            wb(1'b1, fber_pkg::ADR_TBL, 32'h5a0000 + 32'(i));
        end
        check("irq_hold_released", 32'h0, {31'h0, irq_hold});
        unlock();
        stall_cyc = 0;
        link(fber_pkg::SEL_CTL, 16'hc001);
        // held off by the controller until the cycle ends
        wb(1'b1, fber_pkg::ADR_TBL, 32'h0);
        check("row_words", 32'h40, we_cnt);
        check("prog_stall", fber_pkg::ROW_WORDS + fber_pkg::PROG_CYC, stall_cyc);
        stat(32'h0000_4001, "prog_done");
        wb(1'b1, 8'h10, 32'hffff_ffff);
        wb(1'b0, 8'h10, 32'h0);
        check("unmapped_read", 32'h0, st);
        stat(32'h0000_4001, "unmapped_ignored");
    endtask
    initial begin
        repeat (3) @(posedge sys_clk);
        nrst <= 1'b1;
        @(posedge sys_clk);
        t_refusals();
        t_erase();
        t_program();
        summarize();
    end
endmodule // fber_tb
`default_nettype wire
